// file: design/sccs_top.sv
// System clock source control: crystal control, clock mode register and glitch-free mux
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Bit 7 of the crystal control register turns the crystal oscillator on when set and off when clear.
// - Bits 6:5 of the crystal control register set crystal drive: 01 low, 10 medium, 11 high.
// - The system clock comes from exactly one of crystal, divided fast RC or slow RC.
// - A clock mode write makes the new selection take effect at once with no further command.
// - A later write clearing clock mode bit 4 turns the fast RC off at once, which also stops the system clock while the fast RC is chosen.
// - A later write clearing clock mode bit 2 turns the slow RC off at once, even while the slow RC is chosen.
// - Clock mode 0xA6 or 0xB0 selects the crystal and 0xF4 selects the slow RC.
// - Clock mode 0x14 from fast RC divided by two moves straight to fast RC divided by four.
// - Clock mode 0xB4 selects the crystal while keeping the fast RC enabled.
// - Clock mode bit 4 enables the fast RC and bit 2 the slow RC, each on its own.
// - Both internal RC oscillators run after reset before any clock mode write.
module sccs_top
	import sccs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        CE,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// Oscillator clocks from the analog side
	input  wire logic        CRYSTAL_OSCILLATOR_IN,
	input  wire logic        FAST_INTERNAL_RC_IN,
	input  wire logic        SLOW_INTERNAL_RC_IN,
	// Oscillator controls
	output logic             CRYSTAL_OSCILLATOR_EN,
	output logic      [1:0]  CRYSTAL_DRIVE,
	output logic             FAST_INTERNAL_RC_EN,
	output logic             SLOW_INTERNAL_RC_EN,
	// System clock
	output logic             SYS_CLK_OUT,
	output logic             CLK_SWITCHING
);

	logic [7:0]            crystal_osc_control;
	logic [7:0]            clock_mode;
	logic [SCCS_OSC_N-1:0] sync1;
	logic [SCCS_OSC_N-1:0] sync2;
	logic                  fast_prev;
	logic [SCCS_DIV_W-1:0] div_cnt;
	logic [4:0]            pend_code;
	sccs_src_t             pend_src;
	logic [2:0]            pend_div;
	sccs_src_t             act_src;
	logic [2:0]            act_div;
	sccs_state_t           state;
	logic                  bus_req;
	logic                  bus_wr;
	logic [5:0]            bus_idx;
	logic                  new_level;
	logic [31:0]           next_rdata;

	// Selector byte to source and divider tap
	function automatic logic [4:0] decode_mode(input logic [7:0] m);
		logic [2:0] sel;
		logic       hi;
		sel = m[SCCS_MODE_SEL_HI:SCCS_MODE_SEL_LO];
		hi  = m[SCCS_MODE_DIV_BIT];
		case (sel)
			SCCS_SEL_SLOW:   decode_mode = {SCCS_SRC_SLOW, SCCS_DIV2};
			SCCS_SEL_XTAL:   decode_mode = {SCCS_SRC_XTAL, SCCS_DIV2};
			SCCS_SEL_F2_8:   decode_mode = {SCCS_SRC_FAST, hi ? SCCS_DIV8 : SCCS_DIV2};
			SCCS_SEL_F4_16:  decode_mode = {SCCS_SRC_FAST, hi ? SCCS_DIV16 : SCCS_DIV4};
			SCCS_SEL_F32_64: decode_mode = {SCCS_SRC_FAST, hi ? SCCS_DIV32 : SCCS_DIV64};
			// Unlisted selectors fall back to the always-safe slow RC
			default:         decode_mode = {SCCS_SRC_SLOW, SCCS_DIV2};
		endcase
	endfunction

	// Level of a candidate source
	function automatic logic src_level(input sccs_src_t s, input logic [2:0] d,
		input logic [SCCS_OSC_N-1:0] osc, input logic [SCCS_DIV_W-1:0] cnt);
		case (s)
			SCCS_SRC_XTAL: src_level = osc[SCCS_OSC_XTAL];
			SCCS_SRC_SLOW: src_level = osc[SCCS_OSC_SLOW];
			default:       src_level = cnt[d];
		endcase
	endfunction

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, ack for one cycle

	assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign bus_wr  = bus_req && WB_WE_I && WB_SEL_I[0];
	assign bus_idx = WB_ADR_I[SCCS_ADR_HI:SCCS_ADR_LO];

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			WB_ACK_O <= 1'b0;
		end else if (CE) begin
			WB_ACK_O <= bus_req;
		end
	end

	always_comb begin
		next_rdata = 32'h0;
		case (bus_idx)
			SCCS_IDX_XOSC:   next_rdata[7:0] = crystal_osc_control;
			SCCS_IDX_CLKMD:  next_rdata[7:0] = clock_mode;
			SCCS_IDX_STATUS: begin
				next_rdata[SCCS_ST_PARK_BIT]              = (state == SCCS_ST_PARK);
				next_rdata[SCCS_ST_SRC_HI:SCCS_ST_SRC_LO] = act_src;
				next_rdata[SCCS_ST_DIV_HI:SCCS_ST_DIV_LO] = act_div;
			end
			default:         next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			WB_DAT_O <= 32'h0;
		end else if (CE && bus_req) begin
			WB_DAT_O <= next_rdata;
		end
	end

	chk_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held for more than one cycle");

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			crystal_osc_control <= SCCS_XOSC_RST;
		end else if (CE && bus_wr && bus_idx == SCCS_IDX_XOSC) begin
			crystal_osc_control <= WB_DAT_I[7:0];
		end
	end

	// Reset value keeps both RC oscillators on
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			clock_mode <= SCCS_CLKMD_RST;
		end else if (CE && bus_wr && bus_idx == SCCS_IDX_CLKMD) begin
			clock_mode <= WB_DAT_I[7:0];
		end
	end

	assign CRYSTAL_OSCILLATOR_EN = crystal_osc_control[SCCS_XOSC_EN_BIT];
	assign CRYSTAL_DRIVE         = crystal_osc_control[SCCS_XOSC_DRV_HI:SCCS_XOSC_DRV_LO];
	assign FAST_INTERNAL_RC_EN   = clock_mode[SCCS_FAST_EN_BIT];
	assign SLOW_INTERNAL_RC_EN   = clock_mode[SCCS_SLOW_EN_BIT];
	assign pend_code             = decode_mode(clock_mode);
	assign pend_src              = sccs_src_t'(pend_code[4:3]);
	assign pend_div              = pend_code[2:0];

	chk_xtal_enable: assert property (CE && bus_wr && bus_idx == SCCS_IDX_XOSC
		|=> CRYSTAL_OSCILLATOR_EN == $past(WB_DAT_I[SCCS_XOSC_EN_BIT]))
		else $error("crystal enable does not follow write");
	chk_xtal_drive: assert property (CE && bus_wr && bus_idx == SCCS_IDX_XOSC
		|=> CRYSTAL_DRIVE == $past(WB_DAT_I[SCCS_XOSC_DRV_HI:SCCS_XOSC_DRV_LO]))
		else $error("crystal drive does not follow write");
	chk_rc_enables: assert property (CE && bus_wr && bus_idx == SCCS_IDX_CLKMD
		|=> FAST_INTERNAL_RC_EN == $past(WB_DAT_I[SCCS_FAST_EN_BIT])
			&& SLOW_INTERNAL_RC_EN == $past(WB_DAT_I[SCCS_SLOW_EN_BIT]))
		else $error("RC enables do not follow write");
	chk_boot_rc_on: assert property ($rose(RESETN) |-> FAST_INTERNAL_RC_EN && SLOW_INTERNAL_RC_EN)
		else $error("RC oscillators not both on after reset");
	chk_sel_at_once: assert property (CE && bus_wr && bus_idx == SCCS_IDX_CLKMD
		|=> {pend_src, pend_div} == decode_mode($past(WB_DAT_I[7:0])))
		else $error("selection not updated on write");
	chk_xtal_select: assert property (CE && bus_wr && bus_idx == SCCS_IDX_CLKMD
		&& (WB_DAT_I[7:0] == 8'ha6 || WB_DAT_I[7:0] == 8'hb0) |=> pend_src == SCCS_SRC_XTAL)
		else $error("crystal not selected");
	chk_slow_select: assert property (CE && bus_wr && bus_idx == SCCS_IDX_CLKMD
		&& WB_DAT_I[7:0] == 8'hf4 |=> pend_src == SCCS_SRC_SLOW)
		else $error("slow RC not selected");
	chk_div4_select: assert property (CE && bus_wr && bus_idx == SCCS_IDX_CLKMD
		&& WB_DAT_I[7:0] == 8'h14 |=> pend_src == SCCS_SRC_FAST && pend_div == SCCS_DIV4)
		else $error("fast RC divide by four not selected");
	chk_xtal_keep_fast: assert property (CE && bus_wr && bus_idx == SCCS_IDX_CLKMD
		&& WB_DAT_I[7:0] == 8'hb4 |=> pend_src == SCCS_SRC_XTAL && FAST_INTERNAL_RC_EN)
		else $error("crystal select dropped fast RC");

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator synchronisers and fast RC divider

	generate
		for (genvar i = 0; i < SCCS_OSC_N; i++) begin : g_sync
			always_ff @(posedge CLK) begin
				if (!RESETN) begin
					sync1[i] <= 1'b0;
					sync2[i] <= 1'b0;
				end else if (CE) begin
					sync1[i] <= (i == SCCS_OSC_XTAL) ? CRYSTAL_OSCILLATOR_IN :
						(i == SCCS_OSC_FAST) ? FAST_INTERNAL_RC_IN : SLOW_INTERNAL_RC_IN;
					sync2[i] <= sync1[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			fast_prev <= 1'b0;
			div_cnt   <= '0;
		end else if (CE) begin
			fast_prev <= sync2[SCCS_OSC_FAST];
			if (sync2[SCCS_OSC_FAST] && !fast_prev) begin
				div_cnt <= div_cnt + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Glitch-free mux: leave the old source only when low, rejoin the new one only when low

	assign new_level = src_level(act_src, act_div, sync2, div_cnt);

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state       <= SCCS_ST_RUN;
			act_src     <= SCCS_SRC_FAST;
			act_div     <= SCCS_DIV2;
			SYS_CLK_OUT <= 1'b0;
		end else if (CE) begin
			case (state)
				SCCS_ST_RUN: begin
					if ({pend_src, pend_div} != {act_src, act_div} && !SYS_CLK_OUT) begin
						state       <= SCCS_ST_PARK;
						act_src     <= pend_src;
						act_div     <= pend_div;
						SYS_CLK_OUT <= 1'b0;
					end else begin
						SYS_CLK_OUT <= new_level;
					end
				end
				SCCS_ST_PARK: begin
					// A new source stuck high parks here forever, the hang software must avoid
					SYS_CLK_OUT <= 1'b0;
					if (!new_level) begin
						state <= SCCS_ST_RUN;
					end
				end
				default: begin
					state       <= SCCS_ST_RUN;
					SYS_CLK_OUT <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			CLK_SWITCHING <= 1'b0;
		end else if (CE) begin
			CLK_SWITCHING <= ({pend_src, pend_div} != {act_src, act_div}) || state == SCCS_ST_PARK;
		end
	end

	chk_park_low: assert property (state == SCCS_ST_PARK |=> !SYS_CLK_OUT)
		else $error("clock output high while parked");
	chk_leave_low: assert property ($changed({act_src, act_div})
		|-> $past(state) == SCCS_ST_RUN && !$past(SYS_CLK_OUT) && state == SCCS_ST_PARK)
		else $error("source left while output high");
	chk_three_src: assert property (act_src == SCCS_SRC_FAST || act_src == SCCS_SRC_XTAL
		|| act_src == SCCS_SRC_SLOW)
		else $error("active source outside the three");

endmodule

// file: design/sccs_pkg.sv
// Constants and types for the system clock source control block
package sccs_pkg;

	// Register word indices; byte address is four times the index
	localparam logic [5:0] SCCS_IDX_XOSC   = 6'h0a;
	localparam logic [5:0] SCCS_IDX_CLKMD  = 6'h03;
	localparam logic [5:0] SCCS_IDX_STATUS = 6'h04;
	localparam int         SCCS_ADR_LO     = 2;
	localparam int         SCCS_ADR_HI     = 7;

	// Reset values
	localparam logic [7:0] SCCS_XOSC_RST  = 8'h00;
	localparam logic [7:0] SCCS_CLKMD_RST = 8'h34;

	// Field positions
	localparam int SCCS_XOSC_EN_BIT  = 7;
	localparam int SCCS_XOSC_DRV_HI  = 6;
	localparam int SCCS_XOSC_DRV_LO  = 5;
	localparam int SCCS_FAST_EN_BIT  = 4;
	localparam int SCCS_SLOW_EN_BIT  = 2;
	localparam int SCCS_MODE_SEL_HI  = 7;
	localparam int SCCS_MODE_SEL_LO  = 5;
	localparam int SCCS_MODE_DIV_BIT = 3;
	localparam int SCCS_ST_PARK_BIT  = 0;
	localparam int SCCS_ST_SRC_LO    = 1;
	localparam int SCCS_ST_SRC_HI    = 2;
	localparam int SCCS_ST_DIV_LO    = 3;
	localparam int SCCS_ST_DIV_HI    = 5;

	// Source selector codes in the clock mode byte
	localparam logic [2:0] SCCS_SEL_SLOW   = 3'h7;
	localparam logic [2:0] SCCS_SEL_XTAL   = 3'h5;
	localparam logic [2:0] SCCS_SEL_F2_8   = 3'h1;
	localparam logic [2:0] SCCS_SEL_F4_16  = 3'h0;
	localparam logic [2:0] SCCS_SEL_F32_64 = 3'h3;

	// Fast RC divider taps: divide by two to the (tap + 1)
	localparam logic [2:0] SCCS_DIV2  = 3'h0;
	localparam logic [2:0] SCCS_DIV4  = 3'h1;
	localparam logic [2:0] SCCS_DIV8  = 3'h2;
	localparam logic [2:0] SCCS_DIV16 = 3'h3;
	localparam logic [2:0] SCCS_DIV32 = 3'h4;
	localparam logic [2:0] SCCS_DIV64 = 3'h5;
	localparam int         SCCS_DIV_W = 6;

	// Oscillator input indices and oscillator count
	localparam int SCCS_OSC_XTAL = 0;
	localparam int SCCS_OSC_FAST = 1;
	localparam int SCCS_OSC_SLOW = 2;
	localparam int SCCS_OSC_N    = 3;

	typedef enum logic [1:0] {
		SCCS_SRC_FAST = 2'h0,
		SCCS_SRC_XTAL = 2'h1,
		SCCS_SRC_SLOW = 2'h2
	} sccs_src_t;

	typedef enum logic [1:0] {
		SCCS_ST_RUN  = 2'h1,
		SCCS_ST_PARK = 2'h2
	} sccs_state_t;

endpackage

// file: tb/testbench.sv
// Self-checking bench for the system clock source control block
`timescale 1ns/100ps

module testbench;
	import sccs_pkg::*;

	localparam logic [7:0] A_XOSC = {SCCS_IDX_XOSC, 2'b00};
	localparam logic [7:0] A_MODE = {SCCS_IDX_CLKMD, 2'b00};
	localparam logic [7:0] A_STAT = {SCCS_IDX_STATUS, 2'b00};
	localparam logic [7:0] A_NONE = 8'h3c;

	logic        clk;
	logic        resetn;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w;
	logic [31:0] dat_r;
	logic        ack;
	logic        xo;
	logic        fo;
	logic        so;
	logic        xo_en;
	logic        fast_en;
	logic        slow_en;
	logic [1:0]  drive;
	logic        sys_clk;
	logic [31:0] rd;
	logic        ce;
	logic        sw;
	logic        hold;
	logic [4:0]  prev_sel;
	int          num_errors;
	int          num_checks;
	int          hi_run;

	sccs_top sccs_top_i (
		.CLK                   (clk),
		.RESETN                (resetn),
		.CE                    (ce),
		.WB_CYC_I              (cyc),
		.WB_STB_I              (stb),
		.WB_WE_I               (we),
		.WB_ADR_I              (adr),
		.WB_SEL_I              (sel),
		.WB_DAT_I              (dat_w),
		.WB_DAT_O              (dat_r),
		.WB_ACK_O              (ack),
		.CRYSTAL_OSCILLATOR_IN (xo),
		.FAST_INTERNAL_RC_IN   (fo),
		.SLOW_INTERNAL_RC_IN   (so),
		.CRYSTAL_OSCILLATOR_EN (xo_en),
		.CRYSTAL_DRIVE         (drive),
		.FAST_INTERNAL_RC_EN   (fast_en),
		.SLOW_INTERNAL_RC_EN   (slow_en),
		.SYS_CLK_OUT           (sys_clk),
		.CLK_SWITCHING         (sw)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and oscillators; a disabled oscillator stops low, as the analog cell would
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		xo = 1'b0;
		forever #1000 xo = (xo_en === 1'b1) ? ~xo : 1'b0;
	end
	initial begin
		fo = 1'b0;
		forever #400 fo = (fast_en === 1'b1) ? ~fo : 1'b0;
	end
	initial begin
		so = 1'b0;
		forever #1500 so = (slow_en === 1'b1) ? ~so : 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= {24'h0, d};
		sel <= 4'h1;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	// Poll status until the mux runs from the wanted source
	task automatic wait_src(input logic [1:0] src, input logic [2:0] tap = SCCS_DIV2);
		int n;
		n = 0;
		do begin
			wb(1'b0, A_STAT, 8'h00);
			n++;
		end while ((rd[2:0] !== {src, 1'b0} || (src == SCCS_SRC_FAST && rd[5:3] !== tap)) && n < 100);
		check({29'h0, rd[2:0]}, {29'h0, src, 1'b0});
		if (src == SCCS_SRC_FAST) check({29'h0, rd[5:3]}, {29'h0, tap});
		check({31'h0, sw}, 32'h0);
	endtask

	task automatic mode(input logic [7:0] v, input logic [1:0] src, input logic [2:0] tap = SCCS_DIV2);
		wb(1'b1, A_MODE, v);
		check({30'h0, fast_en, slow_en}, {30'h0, v[4], v[2]});
		check({31'h0, sw}, {31'h0, ({src, tap} != prev_sel)});
		prev_sel = {src, tap};
		wb(1'b0, A_MODE, 8'h00);
		check(rd, {24'h0, v});
		wait_src(src, tap);
	endtask

	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Short high phases on the system clock mean a glitch; shortest accepted is six cycles
	always @(posedge clk) begin
		if (sys_clk === 1'b1) begin
			hi_run++;
		end else begin
			if (hi_run != 0) check(32'(hi_run > 5), 32'h1);
			hi_run = 0;
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		resetn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat_w = 32'h0;
		ce = 1'b1;
		prev_sel = {SCCS_SRC_FAST, SCCS_DIV2};
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		check({29'h0, xo_en, fast_en, slow_en}, 32'h3);
		wb(1'b0, A_XOSC, 8'h00);
		check(rd, 32'h0);
		wb(1'b0, A_MODE, 8'h00);
		check(rd, 32'h34);
		wait_src(SCCS_SRC_FAST, SCCS_DIV2);
		for (int i = 1; i < 4; i++) begin
			wb(1'b1, A_XOSC, {1'b0, i[1:0], 5'h00});
			check({30'h0, drive}, 32'(i));
			check({31'h0, xo_en}, 32'h0);
		end
		wb(1'b1, A_XOSC, 8'hc0);
		check({29'h0, xo_en, drive}, 32'h6);
		// Unmapped place: acked, reads zero, stores nothing
		wb(1'b1, A_NONE, 8'hff);
		wb(1'b0, A_NONE, 8'h00);
		check(rd, 32'h0);
		wb(1'b0, A_XOSC, 8'h00);
		check(rd, 32'hc0);
		// Give the crystal time to settle before it is chosen
		repeat (200) @(posedge clk);
		mode(8'hf4, SCCS_SRC_SLOW);
		mode(8'ha6, SCCS_SRC_XTAL);
		mode(8'ha2, SCCS_SRC_XTAL);
		mode(8'hb4, SCCS_SRC_XTAL);
		mode(8'h34, SCCS_SRC_FAST, SCCS_DIV2);
		mode(8'h14, SCCS_SRC_FAST, SCCS_DIV4);
		mode(8'hb0, SCCS_SRC_XTAL);
		mode(8'ha0, SCCS_SRC_XTAL);
		mode(8'ha4, SCCS_SRC_XTAL);
		mode(8'he4, SCCS_SRC_SLOW);
		// Crystal off once the mux runs from the slow RC
		wb(1'b1, A_XOSC, 8'h00);
		check({31'h0, xo_en}, 32'h0);
		wait_src(SCCS_SRC_SLOW);
		// Freeze for exactly one slow RC period, so the synced phase resumes without a short pulse
		@(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		hold = sys_clk;
		repeat (29) begin
			@(posedge clk);
			check({31'h0, sys_clk}, {31'h0, hold});
		end
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		results();
	end

endmodule
